// *** logic/ucdc_pkg.sv ***
// Purpose: shared constants for the usb charger detection control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bit positions index the synchroniser and event vectors
package ucdc_pkg;
    // positions in the synchronised analog vector
    localparam int SYNC_DP = 0;
    localparam int SYNC_DM = 1;
    localparam int SYNC_CHG = 2;
    localparam int SYNC_DCP = 3;
    localparam int SYNC_DPH = 4;
    localparam int SYNC_DMH = 5;
    localparam int SYNC_VBUS = 6;
    localparam int SYNC_WIDTH = 7;
    // positions in the event-capable status vector
    localparam int ST_DP = 0;
    localparam int ST_DM = 1;
    localparam int ST_CHG = 2;
    localparam int ST_DCP = 3;
    localparam int ST_WIDTH = 4;
    // values after reset
    localparam logic CTRL_RST = 1'h0;
    localparam logic STAT_RST = 1'h0;
    localparam logic [ST_WIDTH-1:0] STVEC_RST = 4'h0;
    // flip-flops from analog pin to status output
    localparam int SYNC_STAGES = 2;
    localparam int STATUS_LATENCY = 3;
endpackage

// *** logic/ucdc_stat_if.sv ***
// Purpose: carries event-capable status bits between control and event logic
// Assumes: all signals on the core clock
// Notes: event_flag is driven by a flip-flop inside the event module
`timescale 1ns/10ps
interface ucdc_stat_if #(parameter int W = 4);
    logic [W-1:0] status;
    logic [W-1:0] enable;
    logic read_clr;
    logic event_flag;
    modport ctrl (output status, output enable, output read_clr,
                  input event_flag);
    modport evt (input status, input enable, input read_clr,
                 output event_flag);
endinterface

// *** logic/ucdc_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous comparator outputs
// Assumes: each bit is an independent level, no bus coherency needed
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module ucdc_sync #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // metastability filter, frozen with the clock enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// *** logic/ucdc_event.sv ***
// Purpose: change detection and sticky charger event flag
// Assumes: status bits already synchronised and registered
// Notes: a change set wins over a read clear in the same cycle
`timescale 1ns/10ps
module ucdc_event
    import ucdc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    ucdc_stat_if.evt bus
);
    logic [ST_WIDTH-1:0] prev_q;
    logic set_evt;

    // a bit that differs from last cycle and is enabled is an event
    assign set_evt = |((bus.status ^ prev_q) & bus.enable);

    // previous status; reset matches the status reset so no false event
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= STVEC_RST;
        end else if (ce) begin
            prev_q <= bus.status;
        end
    end

    // sticky flag, set has priority over the read clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.event_flag <= STAT_RST;
        end else if (ce) begin
            if (set_evt) begin
                bus.event_flag <= 1'h1;
            end else if (bus.read_clr) begin
                bus.event_flag <= 1'h0;
            end
        end
    end

    property p_evt_set;
        @(posedge clk) disable iff (!rstn)
        (ce && set_evt) |=> bus.event_flag;
    endproperty
    a_evt_set: assert property (p_evt_set)
        else $error("enabled status change did not set event flag");

    property p_evt_clear;
        @(posedge clk) disable iff (!rstn)
        (ce && bus.read_clr && !set_evt) |=> !bus.event_flag;
    endproperty
    a_evt_clear: assert property (p_evt_clear)
        else $error("status read did not clear event flag");

    property p_evt_hold;
        @(posedge clk) disable iff (!rstn)
        (!bus.read_clr && bus.event_flag) |=> bus.event_flag;
    endproperty
    a_evt_hold: assert property (p_evt_hold)
        else $error("event flag dropped without a status read");
endmodule

// *** logic/ucdc_ctrl.sv ***
// Purpose: usb battery charger detection switch control and status
// Assumes: control bits and read strobe come from core-clock logic,
//          analog comparator outputs are asynchronous to the core clock
// Notes: detection timing and debounce are left to software
`timescale 1ns/10ps
// Function
// - separate bits connect the 0.6 V source to D+ and to D-.
// - separate bits connect the 100 uA sink to D+ and to D-.
// - both data-line sinks are never closed together, whatever software sets.
// - one bit enables the D+ contact source and D- pull-down together.
// - two status bits give the Schmitt levels of D- and D+.
// - charger port flag follows the D- mid-band comparator.
// - dedicated charger flag follows the D+ mid-band comparator.
// - bus power status reads 0 once VBUS has gone and discharged.
// - with contact source on, D+ level shows 1 open, 0 on contact.
// - primary detection uses D+ source and D- sink, read charger flag.
// - secondary detection uses D- source and D+ sink, read dedicated flag.
// - detection works by polling and also raises a usb interrupt.
// - an enabled change in status bits 3 to 0 sets the event flag.
// - reading status clears the event flag; a set in that cycle wins.
// - insertion of bus power pulses the keyscan interrupt line.
// - second level bits per line read 1 above 2.5 V, 0 below 2.3 V.
module ucdc_ctrl
    import ucdc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CORE_CE,
    input wire logic DPLUS_VSRC_EN,
    input wire logic DMINUS_VSRC_EN,
    input wire logic DPLUS_ISINK_EN,
    input wire logic DMINUS_ISINK_EN,
    input wire logic CONTACT_ISRC_EN,
    input wire logic [3:0] CHARGER_EVENT_ENABLE,
    input wire logic STATUS_READ,
    input wire logic DPLUS_SCHMITT_IN,
    input wire logic DMINUS_SCHMITT_IN,
    input wire logic CHARGER_COMPARATOR,
    input wire logic DEDICATED_COMPARATOR,
    input wire logic DPLUS_HIGH_IN,
    input wire logic DMINUS_HIGH_IN,
    input wire logic BUS_POWER_IN,
    output logic DPLUS_VSRC_ON,
    output logic DMINUS_VSRC_ON,
    output logic DPLUS_ISINK_ON,
    output logic DMINUS_ISINK_ON,
    output logic CONTACT_ISRC_ON,
    output logic DMINUS_PULLDN_ON,
    output logic DPLUS_LEVEL,
    output logic DMINUS_LEVEL,
    output logic CHARGER_PORT_FLAG,
    output logic DEDICATED_CHARGER_FLAG,
    output logic DPLUS_HIGH_LEVEL,
    output logic DMINUS_HIGH_LEVEL,
    output logic BUS_POWER_PRESENT,
    output logic CHARGER_EVENT_FLAG,
    output logic KEYSCAN_IRQ
);
    logic [SYNC_WIDTH-1:0] raw_in;
    logic [SYNC_WIDTH-1:0] sync_lvl;
    logic dplus_vsrc_q;
    logic dminus_vsrc_q;
    logic dplus_isink_q;
    logic dplus_isink_d;
    logic dminus_isink_q;
    logic dminus_isink_d;
    logic contact_isrc_q;
    logic dminus_pulldn_q;
    logic dplus_level_q;
    logic dminus_level_q;
    logic charger_port_q;
    logic dedicated_q;
    logic dplus_high_q;
    logic dminus_high_q;
    logic bus_power_q;
    logic keyscan_q;

    ucdc_stat_if #(.W(ST_WIDTH)) stat_bus ();

    // gather asynchronous analog outputs in one vector
    assign raw_in[SYNC_DP] = DPLUS_SCHMITT_IN;
    assign raw_in[SYNC_DM] = DMINUS_SCHMITT_IN;
    assign raw_in[SYNC_CHG] = CHARGER_COMPARATOR;
    assign raw_in[SYNC_DCP] = DEDICATED_COMPARATOR;
    assign raw_in[SYNC_DPH] = DPLUS_HIGH_IN;
    assign raw_in[SYNC_DMH] = DMINUS_HIGH_IN;
    assign raw_in[SYNC_VBUS] = BUS_POWER_IN;

    // every analog level is resynchronised before anyone looks at it
    ucdc_sync #(.W(SYNC_WIDTH)) u_sync (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .ce(CORE_CE),
        .async_in(raw_in),
        .sync_out(sync_lvl)
    );

    // voltage source switches, one bit per data line
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dplus_vsrc_q <= CTRL_RST;
            dminus_vsrc_q <= CTRL_RST;
        end else if (CORE_CE) begin
            dplus_vsrc_q <= DPLUS_VSRC_EN;
            dminus_vsrc_q <= DMINUS_VSRC_EN;
        end
    end

    // a sink may close only when software asks for it alone and the
    // other sink is already open; this gives break-before-make too,
    // so a swap costs one cycle with both open rather than any overlap
    always_comb begin
        dplus_isink_d = DPLUS_ISINK_EN && !DMINUS_ISINK_EN
                        && !dminus_isink_q;
        dminus_isink_d = DMINUS_ISINK_EN && !DPLUS_ISINK_EN
                         && !dplus_isink_q;
    end

    // current sink switches
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dplus_isink_q <= CTRL_RST;
            dminus_isink_q <= CTRL_RST;
        end else if (CORE_CE) begin
            dplus_isink_q <= dplus_isink_d;
            dminus_isink_q <= dminus_isink_d;
        end
    end

    // contact detect source and D- pull-down share a single bit
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            contact_isrc_q <= CTRL_RST;
            dminus_pulldn_q <= CTRL_RST;
        end else if (CORE_CE) begin
            contact_isrc_q <= CONTACT_ISRC_EN;
            dminus_pulldn_q <= CONTACT_ISRC_EN;
        end
    end

    // registered status levels; software polls these directly
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dplus_level_q <= STAT_RST;
            dminus_level_q <= STAT_RST;
            charger_port_q <= STAT_RST;
            dedicated_q <= STAT_RST;
        end else if (CORE_CE) begin
            dplus_level_q <= sync_lvl[SYNC_DP];
            dminus_level_q <= sync_lvl[SYNC_DM];
            charger_port_q <= sync_lvl[SYNC_CHG];
            dedicated_q <= sync_lvl[SYNC_DCP];
        end
    end

    // second threshold pair for proprietary chargers, no event source
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dplus_high_q <= STAT_RST;
            dminus_high_q <= STAT_RST;
        end else if (CORE_CE) begin
            dplus_high_q <= sync_lvl[SYNC_DPH];
            dminus_high_q <= sync_lvl[SYNC_DMH];
        end
    end

    // bus power presence and a one-cycle pulse on its rising edge
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_power_q <= STAT_RST;
            keyscan_q <= STAT_RST;
        end else if (CORE_CE) begin
            bus_power_q <= sync_lvl[SYNC_VBUS];
            keyscan_q <= sync_lvl[SYNC_VBUS] && !bus_power_q;
        end
    end

    // event-capable bits 3 to 0 and their enables go to the event logic
    assign stat_bus.status[ST_DP] = dplus_level_q;
    assign stat_bus.status[ST_DM] = dminus_level_q;
    assign stat_bus.status[ST_CHG] = charger_port_q;
    assign stat_bus.status[ST_DCP] = dedicated_q;
    assign stat_bus.enable = CHARGER_EVENT_ENABLE;
    assign stat_bus.read_clr = STATUS_READ;

    // sticky event flag; it doubles as the usb interrupt request
    ucdc_event u_event (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .ce(CORE_CE),
        .bus(stat_bus.evt)
    );

    // outputs straight from flip-flops
    assign DPLUS_VSRC_ON = dplus_vsrc_q;
    assign DMINUS_VSRC_ON = dminus_vsrc_q;
    assign DPLUS_ISINK_ON = dplus_isink_q;
    assign DMINUS_ISINK_ON = dminus_isink_q;
    assign CONTACT_ISRC_ON = contact_isrc_q;
    assign DMINUS_PULLDN_ON = dminus_pulldn_q;
    assign DPLUS_LEVEL = dplus_level_q;
    assign DMINUS_LEVEL = dminus_level_q;
    assign CHARGER_PORT_FLAG = charger_port_q;
    assign DEDICATED_CHARGER_FLAG = dedicated_q;
    assign DPLUS_HIGH_LEVEL = dplus_high_q;
    assign DMINUS_HIGH_LEVEL = dminus_high_q;
    assign BUS_POWER_PRESENT = bus_power_q;
    assign CHARGER_EVENT_FLAG = stat_bus.event_flag;
    assign KEYSCAN_IRQ = keyscan_q;

    // three enabled edges carry a pin level to its status output
    sequence s_ce_run;
        CORE_CE ##1 CORE_CE ##1 CORE_CE;
    endsequence

    property p_sink_excl;
        @(posedge CORE_CLK) disable iff (!RSTN)
        !(DPLUS_ISINK_ON && DMINUS_ISINK_ON);
    endproperty
    a_sink_excl: assert property (p_sink_excl)
        else $error("both data-line sinks closed together");

    property p_sink_both_req;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && DPLUS_ISINK_EN && DMINUS_ISINK_EN)
        |=> (!DPLUS_ISINK_ON && !DMINUS_ISINK_ON);
    endproperty
    a_sink_both_req: assert property (p_sink_both_req)
        else $error("a sink closed while both were requested");

    property p_dp_sink;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && DPLUS_ISINK_EN && !DMINUS_ISINK_EN)
        ##1 (CORE_CE && DPLUS_ISINK_EN && !DMINUS_ISINK_EN)
        |=> DPLUS_ISINK_ON;
    endproperty
    a_dp_sink: assert property (p_dp_sink)
        else $error("D+ sink not closed when requested alone");

    property p_dm_sink;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && DMINUS_ISINK_EN && !DPLUS_ISINK_EN)
        ##1 (CORE_CE && DMINUS_ISINK_EN && !DPLUS_ISINK_EN)
        |=> DMINUS_ISINK_ON;
    endproperty
    a_dm_sink: assert property (p_dm_sink)
        else $error("D- sink not closed when requested alone");

    property p_vsrc;
        @(posedge CORE_CLK) disable iff (!RSTN)
        CORE_CE |=> (DPLUS_VSRC_ON == $past(DPLUS_VSRC_EN))
                    && (DMINUS_VSRC_ON == $past(DMINUS_VSRC_EN));
    endproperty
    a_vsrc: assert property (p_vsrc)
        else $error("voltage source switch does not follow its bit");

    property p_contact_pair;
        @(posedge CORE_CLK) disable iff (!RSTN)
        CONTACT_ISRC_ON == DMINUS_PULLDN_ON;
    endproperty
    a_contact_pair: assert property (p_contact_pair)
        else $error("contact source and D- pull-down differ");

    property p_dp_level;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (DPLUS_LEVEL == $past(DPLUS_SCHMITT_IN, 3));
    endproperty
    a_dp_level: assert property (p_dp_level)
        else $error("D+ level not three cycles after its pin");

    property p_chg_flag;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (CHARGER_PORT_FLAG == $past(CHARGER_COMPARATOR, 3));
    endproperty
    a_chg_flag: assert property (p_chg_flag)
        else $error("charger port flag not three cycles after pin");

    property p_dcp_flag;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run
        |=> (DEDICATED_CHARGER_FLAG == $past(DEDICATED_COMPARATOR, 3));
    endproperty
    a_dcp_flag: assert property (p_dcp_flag)
        else $error("dedicated flag not three cycles after pin");

    property p_high_level;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (DMINUS_HIGH_LEVEL == $past(DMINUS_HIGH_IN, 3));
    endproperty
    a_high_level: assert property (p_high_level)
        else $error("D- high level not three cycles after pin");

    property p_vbus;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (BUS_POWER_PRESENT == $past(BUS_POWER_IN, 3));
    endproperty
    a_vbus: assert property (p_vbus)
        else $error("bus power status not three cycles after pin");

    property p_keyscan_rise;
        @(posedge CORE_CLK) disable iff (!RSTN)
        $rose(BUS_POWER_PRESENT) |-> KEYSCAN_IRQ;
    endproperty
    a_keyscan_rise: assert property (p_keyscan_rise)
        else $error("no keyscan pulse on bus power insertion");

    property p_keyscan_pulse;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (KEYSCAN_IRQ && CORE_CE) |=> !KEYSCAN_IRQ;
    endproperty
    a_keyscan_pulse: assert property (p_keyscan_pulse)
        else $error("keyscan pulse longer than one cycle");

    // any enabled change of the four status outputs must raise the event
    property p_irq_change;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && |(CHARGER_EVENT_ENABLE
         & ({DEDICATED_CHARGER_FLAG, CHARGER_PORT_FLAG, DMINUS_LEVEL,
             DPLUS_LEVEL}
            ^ $past({DEDICATED_CHARGER_FLAG, CHARGER_PORT_FLAG,
                     DMINUS_LEVEL, DPLUS_LEVEL}))))
        |=> CHARGER_EVENT_FLAG;
    endproperty
    a_irq_change: assert property (p_irq_change)
        else $error("enabled status change raised no event");

    property p_dm_level;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (DMINUS_LEVEL == $past(DMINUS_SCHMITT_IN, 3));
    endproperty
    a_dm_level: assert property (p_dm_level)
        else $error("D- level not three cycles after its pin");

    property p_dp_high;
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_ce_run |=> (DPLUS_HIGH_LEVEL == $past(DPLUS_HIGH_IN, 3));
    endproperty
    a_dp_high: assert property (p_dp_high)
        else $error("D+ high level not three cycles after pin");

    // a closed sink forces the other one open on the next edge
    property p_bbm_dp;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && DPLUS_ISINK_ON) |=> !DMINUS_ISINK_ON;
    endproperty
    a_bbm_dp: assert property (p_bbm_dp)
        else $error("D- sink closed straight after D+ sink");

    property p_bbm_dm;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (CORE_CE && DMINUS_ISINK_ON) |=> !DPLUS_ISINK_ON;
    endproperty
    a_bbm_dm: assert property (p_bbm_dm)
        else $error("D+ sink closed straight after D- sink");
endmodule

// *** verification/ucdc_port_model.sv ***
// Purpose: far-side port or charger model for the detection bench
// Assumes: switch drives come straight from the block outputs
// Notes: line levels given as comparator results after a 2 ns lag
`timescale 1ns/10ps
module ucdc_port_model #(
    parameter int CDP_DELAY = 8
) (
    input wire logic clk,
    input wire logic [2:0] port_type,
    input wire logic attached,
    input wire logic touched,
    input wire logic [1:0] smart_cfg,
    input wire logic [5:0] sw,
    output wire logic [6:0] pins
);
    localparam logic [2:0] P_CDP = 3'h2;
    localparam logic [2:0] P_DCP = 3'h3;
    localparam logic [2:0] P_PS2 = 3'h4;
    localparam logic [2:0] P_SMART = 3'h5;
    logic prim;
    logic sec;
    logic hi2;
    logic cdp_on;
    int cnt = 0;
    // a charging port turns on its D- source only after a while
    always @(posedge clk) begin
        if (prim && port_type == P_CDP) begin
            if (cnt < CDP_DELAY) cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end
    // primary and secondary set-ups seen from the port side
    assign prim = sw[0] & sw[3];
    assign sec = sw[1] & sw[2];
    assign hi2 = attached & (port_type == P_PS2 || port_type == P_SMART);
    assign cdp_on = (port_type == P_CDP) && (cnt >= CDP_DELAY);
    // lag keeps pin changes clear of the sampling edge
    assign #2 pins[0] = hi2 | (sw[4] & ~touched);
    assign #2 pins[1] = hi2;
    assign #2 pins[2] = sw[1]
                        | (prim & ((port_type == P_DCP) | cdp_on));
    assign #2 pins[3] = sw[0] | (sec & (port_type == P_DCP));
    assign #2 pins[4] = hi2 & (port_type == P_SMART) & smart_cfg[1];
    assign #2 pins[5] = hi2 & (port_type == P_SMART) & smart_cfg[0];
    assign #2 pins[6] = attached;
endmodule

// *** verification/ucdc_ctrl_test.sv ***
// Purpose: self-checking bench for the charger detection control block
// Assumes: inputs driven and outputs sampled on falling edges
// Notes: each expectation carries the cycle it falls due in
`timescale 1ns/10ps
module ucdc_ctrl_test
    import ucdc_pkg::*;
();
    typedef struct {
        int due;
        int kind;
        logic [8:0] val;
        logic [8:0] mask;
    } ucdc_note_type;
    localparam int CDP_DELAY = 8;
    localparam logic [8:0] EV = 9'h080;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] ctl = 5'h00;
    logic [3:0] ev_en = 4'h0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic [2:0] ptype = 3'h0;
    logic att = 1'b0;
    logic touch = 1'b0;
    logic [1:0] scfg = 2'h0;
    logic [5:0] sw_exp = 6'h00;
    wire [5:0] sw;
    wire [6:0] pins;
    wire [8:0] st;
    int cyc = 0;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'hB977C305;
    ucdc_note_type q[$];

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ucdc_ctrl i_dut (
        .CORE_CLK(clk), .RSTN(rstn), .CORE_CE(ce),
        .DPLUS_VSRC_EN(ctl[0]), .DMINUS_VSRC_EN(ctl[1]),
        .DPLUS_ISINK_EN(ctl[2]), .DMINUS_ISINK_EN(ctl[3]),
        .CONTACT_ISRC_EN(ctl[4]), .CHARGER_EVENT_ENABLE(ev_en),
        .STATUS_READ(rd), .DPLUS_SCHMITT_IN(pins[0]),
        .DMINUS_SCHMITT_IN(pins[1]), .CHARGER_COMPARATOR(pins[2]),
        .DEDICATED_COMPARATOR(pins[3]), .DPLUS_HIGH_IN(pins[4]),
        .DMINUS_HIGH_IN(pins[5]), .BUS_POWER_IN(pins[6]),
        .DPLUS_VSRC_ON(sw[0]), .DMINUS_VSRC_ON(sw[1]),
        .DPLUS_ISINK_ON(sw[2]), .DMINUS_ISINK_ON(sw[3]),
        .CONTACT_ISRC_ON(sw[4]), .DMINUS_PULLDN_ON(sw[5]),
        .DPLUS_LEVEL(st[0]), .DMINUS_LEVEL(st[1]),
        .CHARGER_PORT_FLAG(st[2]), .DEDICATED_CHARGER_FLAG(st[3]),
        .DPLUS_HIGH_LEVEL(st[4]), .DMINUS_HIGH_LEVEL(st[5]),
        .BUS_POWER_PRESENT(st[6]), .CHARGER_EVENT_FLAG(st[7]),
        .KEYSCAN_IRQ(st[8])
    );

    ucdc_port_model #(.CDP_DELAY(CDP_DELAY)) i_port (
        .clk(clk), .port_type(ptype), .attached(att), .touched(touch),
        .smart_cfg(scfg), .sw(sw), .pins(pins)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_switch(input logic [5:0] e);
        checks_done++;
        if (sw !== e) begin
            n_errors++;
            $display("[FAIL] %0t switches %h exp %h", $time, sw, e);
        end
    endtask

    task automatic cmp_status(input logic [8:0] e, input logic [8:0] m);
        checks_done++;
        if ((st & m) !== (e & m)) begin
            n_errors++;
            $display("[FAIL] %0t status %h exp %h", $time, st & m, e);
        end
    endtask

    // watcher: takes each note off the queue once its cycle is reached
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            if (q[0].kind == 0) cmp_switch(q[0].val[5:0]);
            else cmp_status(q[0].val, q[0].mask);
            void'(q.pop_front());
        end
    end

    task automatic note(input int k, input int d, input logic [8:0] v,
                        input logic [8:0] m);
        q.push_back('{cyc + d, k, v, m});
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait for every pending note to be checked
    task automatic drain;
        int i;
        for (i = 0; i < 300 && q.size() > 0; i++) tick(1);
        if (q.size() > 0) begin
            n_errors++;
            $display("[FAIL] %0t results never arrived", $time);
            summarize();
        end
    endtask

    // sink model: clash opens both, a swap breaks before it makes
    task automatic set_ctl(input logic [4:0] v);
        logic p;
        logic m;
        p = v[2] & ~v[3] & ~sw_exp[3];
        m = v[3] & ~v[2] & ~sw_exp[2];
        ctl = v;
        sw_exp = {v[4], v[4], m, p, v[1], v[0]};
        note(0, 1, {3'h0, sw_exp}, 9'h03F);
    endtask

    task automatic pulse_read;
        rd = 1'b1;
        note(1, 1, 9'h000, EV);
        tick(1);
        rd = 1'b0;
    endtask

    initial begin
        int c;
        logic [4:0] swap [6];
        logic [2:0] prim_t [4];
        logic [8:0] prim_e [4];
        swap = '{5'h04, 5'h08, 5'h04, 5'h0C, 5'h08, 5'h00};
        prim_t = '{3'h3, 3'h2, 3'h1, 3'h4};
        prim_e = '{9'h004, 9'h004, 9'h000, 9'h003};
        // every output must sit low while reset is held
        tick(19);
        note(0, 1, 9'h000, 9'h03F);
        note(1, 1, 9'h000, 9'h1FF);
        tick(1);
        rstn = 1'b1;
        for (c = 0; c < 24; c++) begin
            set_ctl(5'($random(seed)));
            ev_en = 4'($random(seed));
            rd = 1'($random(seed));
            tick(1);
        end
        // random enables and reads feed the event assertions only
        ev_en = 4'h0;
        rd = 1'b0;
        foreach (swap[k]) begin
            set_ctl(swap[k]);
            tick(1);
        end
        drain();
        $display("test switches done");
        // bus power arrives, contact source on, then the pins touch
        set_ctl(5'h00);
        ptype = 3'h1;
        att = 1'b1;
        note(1, 3, 9'h140, 9'h140);
        note(1, 4, 9'h040, 9'h140);
        tick(6);
        set_ctl(5'h10);
        note(1, 4, 9'h001, 9'h001);
        tick(8);
        touch = 1'b1;
        note(1, 3, 9'h000, 9'h001);
        tick(4);
        att = 1'b0;
        note(1, 3, 9'h000, 9'h040);
        tick(4);
        drain();
        att = 1'b1;
        $display("test contact done");
        // primary detection for port kinds 1 to 4; slow port read late
        foreach (prim_t[k]) begin
            set_ctl(5'h00);
            ptype = prim_t[k];
            tick(6);
            set_ctl(5'h09);
            if (prim_t[k] == 3'h2) note(1, 4, 9'h000, 9'h004);
            note(1, 2 * CDP_DELAY + 4, prim_e[k], 9'h007);
            tick(2 * CDP_DELAY + 6);
        end
        // secondary detection tells a dedicated charger apart
        for (c = 2; c < 4; c++) begin
            set_ctl(5'h00);
            ptype = 3'(c);
            tick(2);
            set_ctl(5'h06);
            note(1, 4, (c == 3) ? 9'h008 : 9'h000, 9'h008);
            tick(6);
        end
        set_ctl(5'h00);
        tick(1);
        set_ctl(5'h01);
        tick(2);
        drain();
        $display("test detection done");
        // proprietary charger line levels, every combination
        ptype = 3'h5;
        for (c = 0; c < 4; c++) begin
            scfg = 2'(c);
            note(1, 3, {3'h0, scfg[0], scfg[1], 4'h3}, 9'h033);
            tick(4);
        end
        drain();
        $display("test proprietary done");
        // events: masked change, enabled change, set beating the read
        ptype = 3'h1;
        set_ctl(5'h10);
        tick(8);
        pulse_read();
        touch = 1'b0;
        note(1, 5, 9'h000, EV);
        tick(6);
        ev_en = 4'h1;
        tick(3);
        note(1, 1, 9'h000, EV);
        touch = 1'b1;
        note(1, 4, EV, EV);
        tick(3);
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        note(1, 1, EV, EV);
        tick(1);
        pulse_read();
        note(1, 3, 9'h000, EV);
        drain();
        $display("test events done");
        // frozen clock enable: loss of bus power must wait for ce
        ce = 1'b0;
        att = 1'b0;
        note(1, 4, 9'h040, 9'h140);
        tick(6);
        ce = 1'b1;
        note(1, 3, 9'h000, 9'h040);
        drain();
        $display("test freeze done");
        summarize();
    end
endmodule
